// *** include/iodm_pkg.sv ***
/*
  Constants, field layouts and types shared by the I/O address decoder
  and register map. Assumes a single 100 MHz system clock.
*/
`default_nettype none

package iodm_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int EE_BUSY_NS    = 1000;
  localparam int EE_BUSY_CYC   = (EE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] EE_CNT_LOAD = 7'(EE_BUSY_CYC - 1);

  // ==========================================================
  // Window geometry
  localparam logic [3:0] CODE_NONE = 4'h0;

  // ==========================================================
  // Counter/timer window offsets
  localparam logic [3:0] OFS_CORE1_DATA  = 4'h0;
  localparam logic [3:0] OFS_CORE1_PTR   = 4'h1;
  localparam logic [3:0] OFS_GEN         = 4'h2;
  localparam logic [3:0] OFS_GEN_ALIAS   = 4'h3;
  localparam logic [3:0] OFS_CORE2_DATA  = 4'h4;
  localparam logic [3:0] OFS_CORE2_PTR   = 4'h5;
  localparam logic [3:0] OFS_INTE        = 4'h6;
  localparam logic [3:0] OFS_INTE_ALIAS  = 4'h7;
  localparam logic [3:0] OFS_EE_DATA     = 4'h8;
  localparam logic [3:0] OFS_EE_ADDR     = 4'h9;
  localparam logic [3:0] OFS_EE_CTRL     = 4'hA;
  localparam logic [3:0] OFS_REV         = 4'hB;
  localparam logic [3:0] OFS_SRC         = 4'hC;
  localparam logic [3:0] OFS_ICS         = 4'hD;
  localparam logic [3:0] OFS_AUX         = 4'hE;
  localparam logic [3:0] OFS_RESET_ID    = 4'hF;

  // ==========================================================
  // Field positions
  localparam int INTE_BIT    = 0;
  localparam int CLKSEL_BIT  = 0;
  localparam int RESET_BIT   = 0;
  localparam int EEC_EN_BIT  = 7;
  localparam int EEC_RW_BIT  = 6;
  localparam int ICS_A_CLR   = 0;
  localparam int ICS_A_DIS   = 1;
  localparam int ICS_A_EN    = 2;
  localparam int ICS_B_CLR   = 4;
  localparam int ICS_B_DIS   = 5;
  localparam int ICS_B_EN    = 6;

  // ==========================================================
  // Values after reset; last counter/timer source
  localparam logic [3:0] SRC_A_RST    = 4'hA;
  localparam logic [3:0] SRC_B_RST    = 4'hC;
  localparam logic [3:0] CT_SRC_LAST  = 4'hB;
  localparam logic [7:0] GEN_OUT_RST  = 8'h00;
  localparam logic [3:0] AUX_RST      = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    IODM_IDLE  = 4'b0001,
    IODM_ISSUE = 4'b0010,
    IODM_CAPT  = 4'b0100,
    IODM_DRIVE = 4'b1000
  } iodm_bus_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] offset;
    logic [7:0] wdata;
  } iodm_ext_req_s;

endpackage

`default_nettype wire

// *** design/iodm_cfg_mem.sv ***
/*
  256 x 8 configuration memory with registered read data.
  Assumes writes and reads on the system clock only.
*/
`timescale 1ns/1ps
`default_nettype none

module iodm_cfg_mem (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);

  logic [7:0] mem [256];

  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem[addr_in];
    end
  end

endmodule // iodm_cfg_mem

`default_nettype wire

// *** design/iodm_decoder.sv ***
/*
  I/O address decoder and register map for a counter/timer and digital
  I/O board on an ISA-style I/O bus. Assumes the counter cores and the
  parallel port units sit outside, answering a request on the next cycle.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Parallel window base is code times 40h
// - Parallel window spans eight bytes
// - Counter window spans sixteen bytes, own code
// - Offset 00h moves data of core one
// - Offset 04h moves data of core two
// - Offset 02h general lines, 03h aliases it
// - Offset 06h interrupt enable, 07h aliases it
// - Offsets 08h-0Ah reach configuration memory
// - Offset 0Bh reads fixed revision byte
// - Offset 0Ch picks each output's source
// - Offset 0Dh enables, disables, clears, shows pending
// - Offset 0Eh drives and reads auxiliary lines
// - Offset 0Fh resets board, reads identity
// - Parallel offsets map two units A,B,C,control
// - Interrupt line driven high or released
// - Source nibbles, reset values 0Ah and 0Ch
// - Writing clear bit drops pending flag
module iodm_decoder
  import iodm_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE  = 8'h21, // Arbitrary value
  parameter logic [7:0] PERSONALITY_ID = 8'h5A  // Arbitrary value
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic [9:0]    bus_addr_in,
  input  wire logic          bus_rd_n_in,
  input  wire logic          bus_wr_n_in,
  input  wire logic [7:0]    bus_data_in,
  output logic      [7:0]    bus_data_out,
  output logic               bus_data_oe_out,
  input  wire logic [3:0]    pio_base_select_jumper_in,
  input  wire logic [3:0]    ct_base_select_jumper_in,
  output iodm_ext_req_s      pio_req_out,
  input  wire logic [7:0]    pio_rdata_in,
  output iodm_ext_req_s      core_req_out,
  input  wire logic [7:0]    core_rdata_in,
  output logic               core_clk_fast_out,
  input  wire logic [7:0]    gen_in,
  output logic      [7:0]    gen_out,
  input  wire logic [3:0]    aux_in,
  output logic      [3:0]    aux_out,
  output logic      [3:0]    aux_oe_out,
  input  wire logic [9:0]    ct_event_in,
  input  wire logic [3:0]    pio_event_in,
  input  wire logic          ext_intr_in,
  output logic               intr_line_a_out,
  output logic               intr_line_a_oe_out,
  output logic               intr_line_b_out,
  output logic               intr_line_b_oe_out,
  output logic               board_reset_out
);

  // ==========================================================
  // Functions
  function automatic logic win_hit(input logic [9:0] a, input logic [3:0] code,
                                   input logic wide);
    win_hit = (code != CODE_NONE) && (a[9:6] == code) &&
              (wide ? (a[5:4] == 2'b00) : (a[5:3] == 3'b000));
  endfunction

  function automatic logic is_core_ofs(input logic [3:0] o);
    is_core_ofs = (o[3] == 1'b0) && (o[1] == 1'b0);
  endfunction

  function automatic logic is_ct_src(input logic [3:0] s);
    is_ct_src = (s <= CT_SRC_LAST);
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Address and data are stable around the strobe, so two stages suffice
  logic [40:0] sync1;
  logic [40:0] sync2;
  logic [9:0]  s_addr;
  logic [7:0]  s_data;
  logic        s_rd_n;
  logic        s_wr_n;
  logic [7:0]  s_gen;
  logic [3:0]  s_aux;
  logic        s_intr;
  logic [3:0]  s_pio_code;
  logic [3:0]  s_ct_code;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {bus_addr_in, bus_data_in, bus_rd_n_in, bus_wr_n_in, gen_in, aux_in,
                ext_intr_in, pio_base_select_jumper_in, ct_base_select_jumper_in};
      sync2 <= sync1;
    end
  end

  assign {s_addr, s_data, s_rd_n, s_wr_n, s_gen, s_aux, s_intr, s_pio_code,
          s_ct_code} = sync2;

  // ==========================================================
  // Strobe edges and decode
  logic       rd_n_prev;
  logic       wr_n_prev;
  logic       rd_edge;
  logic       wr_edge;
  logic       pio_hit;
  logic       ct_raw;
  logic       ct_hit;
  logic       srst;
  logic [3:0] ofs;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_n_prev <= 1'b1;
      wr_n_prev <= 1'b1;
    end else begin
      rd_n_prev <= s_rd_n;
      wr_n_prev <= s_wr_n;
    end
  end

  assign rd_edge = rd_n_prev & ~s_rd_n;
  assign wr_edge = wr_n_prev & ~s_wr_n;
  assign pio_hit = win_hit(s_addr, s_pio_code, 1'b0);
  assign ct_raw  = win_hit(s_addr, s_ct_code, 1'b1);
  assign ct_hit  = ct_raw & ~pio_hit;
  assign ofs     = s_addr[3:0];
  assign srst    = rst_in | board_reset_out;

  logic ct_wr;
  assign ct_wr = wr_edge & ct_hit;

  // ==========================================================
  // Requests to parallel units and counter cores
  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      pio_req_out  <= '0;
      core_req_out <= '0;
    end else begin
      pio_req_out.wr  <= wr_edge & pio_hit;
      pio_req_out.rd  <= rd_edge & pio_hit;
      core_req_out.wr <= ct_wr & is_core_ofs(ofs);
      core_req_out.rd <= rd_edge & ct_hit & is_core_ofs(ofs);
      if ((wr_edge | rd_edge) & pio_hit) begin
        pio_req_out.offset <= {1'b0, ofs[2:0]};
        pio_req_out.wdata  <= s_data;
      end
      if ((wr_edge | rd_edge) & ct_hit) begin
        core_req_out.offset <= ofs;
        core_req_out.wdata  <= s_data;
      end
    end
  end

  // ==========================================================
  // General lines, clock select, auxiliary lines, board reset
  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      gen_out <= GEN_OUT_RST;
    end else if (ct_wr && (ofs == OFS_GEN || ofs == OFS_GEN_ALIAS)) begin
      gen_out <= s_data;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      core_clk_fast_out <= 1'b0;
    end else if (ct_wr && ofs == OFS_REV) begin
      core_clk_fast_out <= s_data[CLKSEL_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      aux_out    <= AUX_RST;
      aux_oe_out <= AUX_RST;
    end else if (ct_wr && ofs == OFS_AUX) begin
      aux_oe_out <= s_data[7:4];
      aux_out    <= s_data[3:0];
    end
  end

  // Pulse lasts one cycle; it also clears every register here except the pin synchronisers and strobe history
  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      board_reset_out <= 1'b0;
    end else begin
      board_reset_out <= ct_wr && (ofs == OFS_RESET_ID) && s_data[RESET_BIT];
    end
  end

  // ==========================================================
  // Interrupt source, enable and pending
  logic [3:0]  src_a;
  logic [3:0]  src_b;
  logic        en_a;
  logic        en_b;
  logic        pend_a;
  logic        pend_b;
  logic        lvl_a_prev;
  logic        lvl_b_prev;
  logic        rise_a;
  logic        rise_b;
  logic [15:0] events;
  logic        inte_wr;
  logic        ics_wr;

  assign events  = {pio_event_in, s_gen[0], s_intr, ct_event_in};
  assign rise_a  = events[src_a] & ~lvl_a_prev;
  assign rise_b  = events[src_b] & ~lvl_b_prev;
  assign inte_wr = ct_wr && (ofs == OFS_INTE || ofs == OFS_INTE_ALIAS);
  assign ics_wr  = ct_wr && (ofs == OFS_ICS);

  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      src_a <= SRC_A_RST;
      src_b <= SRC_B_RST;
    end else if (ct_wr && ofs == OFS_SRC) begin
      src_a <= s_data[3:0];
      src_b <= s_data[7:4];
    end
  end

  // Enables on 06h/07h only touch lines fed by counter/timer sources
  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      en_a <= 1'b0;
      en_b <= 1'b0;
    end else if (inte_wr) begin
      if (is_ct_src(src_a)) en_a <= s_data[INTE_BIT];
      if (is_ct_src(src_b)) en_b <= s_data[INTE_BIT];
    end else if (ics_wr) begin
      if (s_data[ICS_A_EN]) en_a <= 1'b1;
      else if (s_data[ICS_A_DIS]) en_a <= 1'b0;
      if (s_data[ICS_B_EN]) en_b <= 1'b1;
      else if (s_data[ICS_B_DIS]) en_b <= 1'b0;
    end
  end

  // A new edge in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      lvl_a_prev <= 1'b0;
      lvl_b_prev <= 1'b0;
      pend_a     <= 1'b0;
      pend_b     <= 1'b0;
    end else begin
      lvl_a_prev <= events[src_a];
      lvl_b_prev <= events[src_b];
      if (rise_a & en_a) pend_a <= 1'b1;
      else if (ics_wr & s_data[ICS_A_CLR]) pend_a <= 1'b0;
      if (rise_b & en_b) pend_b <= 1'b1;
      else if (ics_wr & s_data[ICS_B_CLR]) pend_b <= 1'b0;
    end
  end

  // Drive high only, so several boards may share a pulled-down line
  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      intr_line_a_out    <= 1'b0;
      intr_line_a_oe_out <= 1'b0;
      intr_line_b_out    <= 1'b0;
      intr_line_b_oe_out <= 1'b0;
    end else begin
      intr_line_a_out    <= pend_a & en_a;
      intr_line_a_oe_out <= pend_a & en_a;
      intr_line_b_out    <= pend_b & en_b;
      intr_line_b_oe_out <= pend_b & en_b;
    end
  end

  // ==========================================================
  // Configuration memory access
  logic [7:0] ee_data;
  logic [7:0] ee_addr;
  logic       ee_busy;
  logic       ee_rw;
  logic [6:0] ee_cnt;
  logic       ee_start;
  logic [7:0] mem_rdata;

  // A start while busy is ignored
  assign ee_start = ct_wr && (ofs == OFS_EE_CTRL) && s_data[EEC_EN_BIT] && !ee_busy;

  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      ee_busy <= 1'b0;
      ee_rw   <= 1'b0;
      ee_cnt  <= 7'h00;
    end else if (ee_start) begin
      ee_busy <= 1'b1;
      ee_rw   <= s_data[EEC_RW_BIT];
      ee_cnt  <= EE_CNT_LOAD;
    end else if (ee_busy) begin
      ee_cnt  <= ee_cnt - 7'h01;
      ee_busy <= (ee_cnt != 7'h00);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      ee_data <= 8'h00;
      ee_addr <= 8'h00;
    end else begin
      if (ct_wr && ofs == OFS_EE_DATA) ee_data <= s_data;
      else if (ee_busy && ee_rw && ee_cnt == 7'h00) ee_data <= mem_rdata;
      if (ct_wr && ofs == OFS_EE_ADDR && !ee_busy) ee_addr <= s_data;
    end
  end

  iodm_cfg_mem u_cfg_mem (
    .sys_clk_in (sys_clk_in),
    .rst_in     (srst),
    .wr_en_in   (ee_start & ~s_data[EEC_RW_BIT]),
    .addr_in    (ee_addr),
    .wdata_in   (ee_data),
    .rdata_out  (mem_rdata)
  );

  // ==========================================================
  // Read cycle: issue, capture, drive until the strobe ends
  iodm_bus_state_e state;
  logic            rd_pio;
  logic [3:0]      rd_ofs;
  logic [7:0]      rd_mux;
  logic            inte_view;
  logic [3:0]      aux_view;

  assign inte_view = (en_a & is_ct_src(src_a)) | (en_b & is_ct_src(src_b));
  assign aux_view  = (aux_oe_out & aux_out) | (~aux_oe_out & s_aux);

  always_comb begin
    rd_mux = 8'h00;
    if (rd_pio) begin
      rd_mux = pio_rdata_in;
    end else begin
      case (rd_ofs)
        OFS_GEN, OFS_GEN_ALIAS:  rd_mux = s_gen;
        OFS_INTE, OFS_INTE_ALIAS: rd_mux = {7'h00, inte_view};
        OFS_EE_DATA:  rd_mux = ee_data;
        OFS_EE_ADDR:  rd_mux = ee_addr;
        OFS_EE_CTRL:  rd_mux = {1'b0, ee_rw, ee_busy, 5'h00};
        OFS_REV:      rd_mux = REVISION_CODE;
        OFS_SRC:      rd_mux = {src_b, src_a};
        OFS_ICS:      rd_mux = {1'b0, en_b, 1'b0, pend_b, 1'b0, en_a, 1'b0, pend_a};
        OFS_AUX:      rd_mux = {aux_oe_out, aux_view};
        OFS_RESET_ID: rd_mux = PERSONALITY_ID;
        default:      rd_mux = core_rdata_in;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst) begin
      state           <= IODM_IDLE;
      rd_pio          <= 1'b0;
      rd_ofs          <= 4'h0;
      bus_data_out    <= 8'h00;
      bus_data_oe_out <= 1'b0;
    end else begin
      unique case (state)
        IODM_IDLE: begin
          if (rd_edge && (pio_hit || ct_hit)) begin
            rd_pio <= pio_hit;
            rd_ofs <= ofs;
            state  <= IODM_ISSUE;
          end
        end
        IODM_ISSUE: state <= IODM_CAPT;
        IODM_CAPT: begin
          bus_data_out    <= rd_mux;
          bus_data_oe_out <= 1'b1;
          state           <= IODM_DRIVE;
        end
        IODM_DRIVE: begin
          if (s_rd_n) begin
            bus_data_oe_out <= 1'b0;
            state           <= IODM_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst);

  sequence s_pend_then_line;
    pend_a ##1 (intr_line_a_oe_out && intr_line_a_out);
  endsequence

  sequence s_reset_pulse;
    board_reset_out ##1 !board_reset_out;
  endsequence

  property p_pio_prio;
    rd_edge && pio_hit && ct_raw |=> pio_req_out.rd && !core_req_out.rd;
  endproperty
  a_pio_prio: assert property (p_pio_prio) else $error("core read on overlap");

  property p_zero_code;
    (s_pio_code == CODE_NONE) |-> !pio_hit;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("zero code decoded");

  property p_src_reset;
    @(posedge sys_clk_in) disable iff (rst_in)
      $fell(board_reset_out) |-> (src_a == SRC_A_RST) && (src_b == SRC_B_RST);
  endproperty
  a_src_reset: assert property (p_src_reset) else $error("bad source reset");

  property p_clear;
    ics_wr && s_data[ICS_A_CLR] && !(rise_a && en_a) |=> !pend_a;
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");

  property p_set_line;
    rise_a && en_a && !ics_wr && !inte_wr |=> s_pend_then_line;
  endproperty
  a_set_line: assert property (p_set_line) else $error("line not driven");

  property p_ee_busy;
    ee_start |=> ee_busy [*8];
  endproperty
  a_ee_busy: assert property (p_ee_busy) else $error("busy dropped early");

  property p_rd_drive;
    rd_edge && pio_hit && state == IODM_IDLE |=> ##2 bus_data_oe_out
      && bus_data_out == $past(pio_rdata_in);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data late");

  property p_rev;
    state == IODM_CAPT && !rd_pio && rd_ofs == OFS_REV |=> bus_data_out == REVISION_CODE;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision byte");

  property p_gen_alias;
    ct_wr && ofs == OFS_GEN_ALIAS |=> gen_out == $past(s_data);
  endproperty
  a_gen_alias: assert property (p_gen_alias) else $error("alias write lost");

  property p_board_reset;
    @(posedge sys_clk_in) disable iff (rst_in)
      ct_wr && !board_reset_out && ofs == OFS_RESET_ID && s_data[RESET_BIT]
        |=> s_reset_pulse;
  endproperty
  a_board_reset: assert property (p_board_reset) else $error("no reset pulse");

endmodule // iodm_decoder

`default_nettype wire

// *** verification/iodm_unit_model.sv ***
/*
  Behavioural model of the parallel units and counter cores behind the
  decoder. Assumes requests arrive as one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module iodm_unit_model
  import iodm_pkg::*;
(
  input  wire logic    sys_clk_in,
  input  wire iodm_ext_req_s req_in,
  output logic [7:0]   rdata_out
);
  // ==========================================================
  // Register file
  logic [7:0] mem [0:15];

  // Idle data toggles so a late capture cannot pass by chance
  always_ff @(posedge sys_clk_in) begin
    if (req_in.wr) begin
      mem[req_in.offset] <= req_in.wdata;
    end
    if (req_in.rd) begin
      rdata_out <= mem[req_in.offset];
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule // iodm_unit_model

`default_nettype wire

// *** verification/iodm_decoder_tb_top.sv ***
/*
  Self-checking bench for the decoder: host bus cycles on the pins, with
  unit and core models answering one cycle after each request.
*/
`timescale 1ns/1ps
`default_nettype none

module iodm_decoder_tb_top
  import iodm_pkg::*;
();
  // ==========================================================
  // Signals
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] addr = 10'h000;
  logic rd_n = 1'b1, wr_n = 1'b1;
  logic [7:0] din = 8'h00, dout, gen_in = 8'hA4, gen_out, prd, crd;
  logic [3:0] pio_code = 4'h1, ct_code = 4'h4, aux_in = 4'h9, aux_out, aux_oe;
  logic [9:0] ct_ev = 10'h000;
  logic [3:0] pio_ev = 4'h0;
  logic ext_intr = 1'b0;
  logic oe, clk_fast, ia, ia_oe, ib, ib_oe, brst, brst_seen = 1'b0;
  iodm_ext_req_s preq, creq;
  int bad_count = 0, tests_run = 0, cyc = 0;
  logic [7:0] v;
  localparam logic [9:0] CT = 10'h100;
  localparam logic [9:0] PIO = 10'h040;

  always #5 sys_clk_in = ~sys_clk_in;

  iodm_decoder iodm_decoder_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .bus_addr_in(addr), .bus_rd_n_in(rd_n), .bus_wr_n_in(wr_n), .bus_data_in(din),
    .bus_data_out(dout), .bus_data_oe_out(oe), .pio_base_select_jumper_in(pio_code),
    .ct_base_select_jumper_in(ct_code), .pio_req_out(preq), .pio_rdata_in(prd),
    .core_req_out(creq), .core_rdata_in(crd), .core_clk_fast_out(clk_fast),
    .gen_in(gen_in), .gen_out(gen_out), .aux_in(aux_in), .aux_out(aux_out),
    .aux_oe_out(aux_oe), .ct_event_in(ct_ev), .pio_event_in(pio_ev), .ext_intr_in(ext_intr),
    .intr_line_a_out(ia), .intr_line_a_oe_out(ia_oe), .intr_line_b_out(ib),
    .intr_line_b_oe_out(ib_oe), .board_reset_out(brst));
  iodm_unit_model iodm_unit_model_i (.sys_clk_in(sys_clk_in), .req_in(preq), .rdata_out(prd));
  iodm_unit_model iodm_core_model_i (.sys_clk_in(sys_clk_in), .req_in(creq), .rdata_out(crd));

  // ==========================================================
  // Reporting
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(negedge sys_clk_in) begin
    cyc++;
    if (brst === 1'b1) brst_seen <= 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Host bus cycles
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr = a;
    din = d;
    wr_n = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    wr_n = 1'b1;
    repeat (4) @(negedge sys_clk_in);
  endtask

  // Strobe held until the edge that sees the drive; no drive gives X
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    int n = 0;
    @(negedge sys_clk_in);
    addr = a;
    rd_n = 1'b0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (oe !== 1'b1 && n < 12);
    d = (oe === 1'b1) ? dout : 8'hXX;
    rd_n = 1'b1;
    repeat (4) @(negedge sys_clk_in);
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    rchk(CT + 10'h00C, 8'hCA);
    rchk(CT + 10'h00B, 8'h21);
    rchk(CT + 10'h00F, 8'h5A);
    rchk(CT + 10'h00D, 8'h00);
    // Reset sources: A from the interrupt pin, B from unit one C0
    wr(CT + 10'h00D, 8'h44);
    ext_intr = 1'b1;
    pio_ev = 4'h1;
    repeat (5) @(negedge sys_clk_in);
    chk({ia, ia_oe, ib, ib_oe}, 8'h0F);
    rchk(CT + 10'h00D, 8'h55);
    wr(CT + 10'h00D, 8'h33);
    rchk(CT + 10'h00D, 8'h00);
    chk({ia, ia_oe, ib, ib_oe}, 8'h00);
    ext_intr = 1'b0;
    pio_ev = 4'h0;
    for (int i = 0; i < 8; i++) wr(PIO + 10'(i), 8'h30 + 8'(i));
    for (int i = 0; i < 8; i++) rchk(PIO + 10'(i), 8'h30 + 8'(i));
    wr(CT + 10'h001, 8'h11);
    wr(CT + 10'h000, 8'h77);
    wr(CT + 10'h005, 8'h22);
    wr(CT + 10'h004, 8'h99);
    rchk(CT + 10'h001, 8'h11);
    rchk(CT + 10'h000, 8'h77);
    rchk(CT + 10'h004, 8'h99);
    rchk(CT + 10'h005, 8'h22);
    // No drive at all outside the windows
    rd(PIO + 10'h008, v);
    chk(v, 8'hXX);
    rd(CT + 10'h010, v);
    chk(v, 8'hXX);
    rchk(CT + 10'h002, 8'hA4);
    rchk(CT + 10'h003, 8'hA4);
    wr(CT + 10'h003, 8'h3C);
    chk(gen_out, 8'h3C);
    wr(CT + 10'h00E, 8'hF5);
    chk({aux_oe, aux_out}, 8'hF5);
    rchk(CT + 10'h00E, 8'hF5);
    wr(CT + 10'h00E, 8'h05);
    rchk(CT + 10'h00E, 8'h09);
    wr(CT + 10'h00B, 8'h01);
    chk(clk_fast, 8'h01);
    // Interrupts: A from counter output 0, B from general input 0
    wr(CT + 10'h00C, 8'hB0);
    rchk(CT + 10'h00C, 8'hB0);
    wr(CT + 10'h00D, 8'h44);
    ct_ev[0] = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    chk({ia, ia_oe, ib_oe}, 8'h06);
    rchk(CT + 10'h00D, 8'h45);
    wr(CT + 10'h00D, 8'h01);
    rchk(CT + 10'h00D, 8'h44);
    chk({ia, ia_oe}, 8'h00);
    gen_in[0] = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    chk({ib, ib_oe}, 8'h03);
    wr(CT + 10'h006, 8'h00);
    rchk(CT + 10'h007, 8'h00);
    rchk(CT + 10'h00D, 8'h10);
    chk({ib, ib_oe}, 8'h00);
    // Configuration memory write then read back
    wr(CT + 10'h009, 8'h33);
    wr(CT + 10'h008, 8'h9C);
    wr(CT + 10'h00A, 8'h80);
    repeat (110) @(negedge sys_clk_in);
    wr(CT + 10'h008, 8'h00);
    wr(CT + 10'h00A, 8'hC0);
    rchk(CT + 10'h00A, 8'h60);
    repeat (110) @(negedge sys_clk_in);
    rchk(CT + 10'h00A, 8'h40);
    rchk(CT + 10'h008, 8'h9C);
    wr(CT + 10'h00F, 8'h01);
    chk(brst_seen, 8'h01);
    rchk(CT + 10'h00C, 8'hCA);
    chk(gen_out, 8'h00);
    // Zero code switches the parallel window off
    pio_code = 4'h0;
    rd(PIO, v);
    chk(v, 8'hXX);
    // Both windows at 100h: the parallel unit must answer
    pio_code = 4'h4;
    rchk(CT, 8'h30);
    end_sim();
  end
endmodule // iodm_decoder_tb_top

`default_nettype wire
